// >>> design/fdob_regs.vh
// Object dictionary indices, keywords, reset values and timing counts
// for the drive object bank. Included by the bank module only.
`ifndef FDOB_REGS_VH
`define FDOB_REGS_VH
// Object indices, used directly as the access index
`define FDOB_IDX_STORE 16'h1010
`define FDOB_IDX_RESTORE 16'h1011
`define FDOB_IDX_EMCY_ID 16'h1014
`define FDOB_IDX_HB_CONSUME 16'h1016
`define FDOB_IDX_HB_PRODUCE 16'h1017
`define FDOB_IDX_IDENTITY 16'h1018
`define FDOB_IDX_OPERATION 16'h2000
`define FDOB_IDX_SPEED 16'h2010
`define FDOB_IDX_TORQUE 16'h2020
// Keywords, first character in the low byte
`define FDOB_KEY_SAVE 32'h65766173
`define FDOB_KEY_LOAD 32'h64616F6C
// Factory defaults of the communication settings
`define FDOB_DEF_HB_CONSUME 32'h00000000
`define FDOB_DEF_HB_PRODUCE 32'h00000000
`define FDOB_DEF_EMCY_BASE 32'h00000080
// Operation word fields
`define FDOB_OP_FWD 0
`define FDOB_OP_REV 1
`define FDOB_OP_VIN_LO 2
`define FDOB_OP_FAULT 8
`define FDOB_OP_RESET 9
`define FDOB_OP_MASK 16'h037F
// Run source value selecting the network as run source
`define FDOB_RUN_SRC_NET 8'h03
// Control method code for open loop vector
`define FDOB_CTRL_OLV 2'h2
// Heartbeat tick: 1 ms at 100 ns clock
`define FDOB_CLK_PERIOD_NS 100
`define FDOB_TICK_NS 1000000
`define FDOB_TICK_CYCLES (`FDOB_TICK_NS / `FDOB_CLK_PERIOD_NS)
// Identity answer, value arbitrary
`define FDOB_IDENTITY_DEF 32'h00001234
`endif

// >>> design/fdob_bank.v
// Object dictionary bank of the fieldbus option card: keyword triggers,
// heartbeat timing, identity and the drive command words.
// Assumes a frame decoder presents one-cycle index accesses synchronous to
// clock_in and a storage engine that answers saves with a done pulse.
`timescale 1ns/1ps
`include "fdob_regs.vh"

// Functional notes
// - SAVE keyword copies comm settings to storage
// - Stored settings apply only after reset events
// - Emergency identifier is read-only, writes rejected
// - Consumer timeout in ms, zero disables supervision
// - Own heartbeat sent every producer period ms
// - Producer period zero sends no heartbeat
// - Identity entry is read-only 32-bit information
// - Run bits act only when source equals 3
// - Bits 2-6 drive five virtual inputs
// - Bit 8 external fault, bit 9 fault reset
// - Speed reference is 16-bit read/write
// - Torque ceiling acts only in open-loop vector
module fdob_bank
(
    input wire clock_in,
    input wire rst_in,
    input wire acc_valid_in,
    input wire acc_write_in,
    input wire [15:0] acc_index_in,
    input wire [31:0] acc_wdata_in,
    input wire [6:0] node_id_in,
    input wire node_reset_in,
    input wire comm_reset_in,
    input wire [31:0] nv_hb_consume_in,
    input wire [31:0] nv_hb_produce_in,
    input wire nv_valid_in,
    input wire nv_done_in,
    input wire master_hb_in,
    input wire [7:0] run_source_select_param_in,
    input wire [1:0] control_method_in,
    output reg acc_ack_out,
    output reg acc_err_out,
    output reg [31:0] acc_rdata_out,
    output reg nv_store_out,
    output reg [31:0] nv_hb_consume_out,
    output reg [31:0] nv_hb_produce_out,
    output reg heartbeat_send_out,
    output reg heartbeat_lost_out,
    output reg run_forward_out,
    output reg run_reverse_out,
    output reg [4:0] virtual_input_out,
    output reg network_external_fault_out,
    output reg fault_reset_out,
    output reg [15:0] speed_reference_out,
    output reg [15:0] torque_ceiling_out,
    output reg torque_ceiling_valid_out
);

    // Active communication settings
    reg [31:0] hb_consume;
    reg [31:0] hb_produce;
    // Storage request pending until engine done
    reg store_busy;
    // Drive command words
    reg [15:0] operation_word;
    reg [15:0] speed_reference;
    reg [15:0] torque_ceiling;
    // Heartbeat timing
    reg [13:0] tick_cnt;
    reg tick;
    reg [31:0] prod_ms;
    reg [31:0] cons_ms;
    // Decoded access strobes
    wire wr = acc_valid_in & acc_write_in;
    wire rd = acc_valid_in & ~acc_write_in;
    wire [31:0] emcy_id = `FDOB_DEF_EMCY_BASE | {25'h0, node_id_in};
    reg known;
    reg writable;
    reg [31:0] next_rdata;

    // Index decode and read mux
    always @*
    begin
        known = 1'b1;
        writable = 1'b1;
        next_rdata = 32'h00000000;
        case (acc_index_in)
            `FDOB_IDX_STORE: next_rdata = 32'h00000001; // Store supported
            `FDOB_IDX_RESTORE: next_rdata = 32'h00000001; // Restore supported
            `FDOB_IDX_EMCY_ID:
            begin
                next_rdata = emcy_id;
                writable = 1'b0;
            end
            `FDOB_IDX_HB_CONSUME: next_rdata = hb_consume;
            `FDOB_IDX_HB_PRODUCE: next_rdata = hb_produce;
            `FDOB_IDX_IDENTITY:
            begin
                next_rdata = `FDOB_IDENTITY_DEF;
                writable = 1'b0;
            end
            `FDOB_IDX_OPERATION: next_rdata = {16'h0000, operation_word};
            `FDOB_IDX_SPEED: next_rdata = {16'h0000, speed_reference};
            `FDOB_IDX_TORQUE: next_rdata = {16'h0000, torque_ceiling};
            default:
            begin
                known = 1'b0;
                writable = 1'b0;
            end
        endcase
    end

    // Access answer one cycle after the request
    always @(posedge clock_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            acc_ack_out <= 1'b0;
            acc_err_out <= 1'b0;
            acc_rdata_out <= 32'h00000000;
        end
        else
        begin
            acc_ack_out <= acc_valid_in;
            acc_err_out <= acc_valid_in & (~known | (acc_write_in & ~writable));
            acc_rdata_out <= rd ? next_rdata : 32'h00000000;
        end
    end

    // Communication settings, store and restore keywords
    always @(posedge clock_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            hb_consume <= `FDOB_DEF_HB_CONSUME;
            hb_produce <= `FDOB_DEF_HB_PRODUCE;
            store_busy <= 1'b0;
            nv_store_out <= 1'b0;
            nv_hb_consume_out <= 32'h00000000;
            nv_hb_produce_out <= 32'h00000000;
        end
        else
        begin
            nv_store_out <= 1'b0;
            if (nv_done_in)
            begin
                store_busy <= 1'b0;
            end
            if ((node_reset_in | comm_reset_in) & nv_valid_in)
            begin
                // Stored image becomes active only here
                hb_consume <= nv_hb_consume_in;
                hb_produce <= nv_hb_produce_in;
            end
            else if (node_reset_in | comm_reset_in)
            begin
                hb_consume <= `FDOB_DEF_HB_CONSUME;
                hb_produce <= `FDOB_DEF_HB_PRODUCE;
            end
            else if (wr)
            begin
                case (acc_index_in)
                    `FDOB_IDX_STORE:
                    begin
                        // Snapshot only on exact keyword and idle engine
                        if (acc_wdata_in == `FDOB_KEY_SAVE && !store_busy)
                        begin
                            nv_store_out <= 1'b1;
                            store_busy <= 1'b1;
                            nv_hb_consume_out <= hb_consume;
                            nv_hb_produce_out <= hb_produce;
                        end
                    end
                    `FDOB_IDX_RESTORE:
                    begin
                        if (acc_wdata_in == `FDOB_KEY_LOAD)
                        begin
                            hb_consume <= `FDOB_DEF_HB_CONSUME;
                            hb_produce <= `FDOB_DEF_HB_PRODUCE;
                        end
                    end
                    `FDOB_IDX_HB_CONSUME: hb_consume <= acc_wdata_in;
                    `FDOB_IDX_HB_PRODUCE: hb_produce <= acc_wdata_in;
                    default:
                    begin
                        hb_consume <= hb_consume;
                    end
                endcase
            end
        end
    end

    // Drive command words
    always @(posedge clock_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            operation_word <= 16'h0000;
            speed_reference <= 16'h0000;
            torque_ceiling <= 16'h0000;
        end
        else if (wr)
        begin
            case (acc_index_in)
                `FDOB_IDX_OPERATION: operation_word <= acc_wdata_in[15:0] & `FDOB_OP_MASK;
                `FDOB_IDX_SPEED: speed_reference <= acc_wdata_in[15:0];
                `FDOB_IDX_TORQUE: torque_ceiling <= acc_wdata_in[15:0];
                default:
                begin
                    operation_word <= operation_word;
                end
            endcase
        end
    end

    // Command outputs towards the drive
    always @(posedge clock_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            run_forward_out <= 1'b0;
            run_reverse_out <= 1'b0;
            virtual_input_out <= 5'h00;
            network_external_fault_out <= 1'b0;
            fault_reset_out <= 1'b0;
            speed_reference_out <= 16'h0000;
            torque_ceiling_out <= 16'h0000;
            torque_ceiling_valid_out <= 1'b0;
        end
        else
        begin
            // Run bits gated by run source selection
            run_forward_out <= operation_word[`FDOB_OP_FWD]
                & (run_source_select_param_in == `FDOB_RUN_SRC_NET);
            run_reverse_out <= operation_word[`FDOB_OP_REV]
                & (run_source_select_param_in == `FDOB_RUN_SRC_NET);
            virtual_input_out <= operation_word[`FDOB_OP_VIN_LO +: 5];
            network_external_fault_out <= operation_word[`FDOB_OP_FAULT];
            fault_reset_out <= operation_word[`FDOB_OP_RESET];
            speed_reference_out <= speed_reference;
            torque_ceiling_out <= torque_ceiling;
            torque_ceiling_valid_out <= (control_method_in == `FDOB_CTRL_OLV);
        end
    end

    // One millisecond tick
    always @(posedge clock_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            tick_cnt <= 14'h0000;
            tick <= 1'b0;
        end
        else if ({18'h0, tick_cnt} == `FDOB_TICK_CYCLES - 1)
        begin
            tick_cnt <= 14'h0000;
            tick <= 1'b1;
        end
        else
        begin
            tick_cnt <= tick_cnt + 14'h0001;
            tick <= 1'b0;
        end
    end

    // Producer heartbeat: pulse each period, silent at zero
    always @(posedge clock_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            prod_ms <= 32'h00000000;
            heartbeat_send_out <= 1'b0;
        end
        else if (hb_produce == 32'h00000000)
        begin
            prod_ms <= 32'h00000000;
            heartbeat_send_out <= 1'b0;
        end
        else if (tick && prod_ms >= hb_produce - 32'h00000001)
        begin
            prod_ms <= 32'h00000000;
            heartbeat_send_out <= 1'b1;
        end
        else
        begin
            prod_ms <= tick ? prod_ms + 32'h00000001 : prod_ms;
            heartbeat_send_out <= 1'b0;
        end
    end

    // Consumer supervision; relies on master beating faster than timeout
    always @(posedge clock_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            cons_ms <= 32'h00000000;
            heartbeat_lost_out <= 1'b0;
        end
        else if (hb_consume == 32'h00000000)
        begin
            cons_ms <= 32'h00000000;
            heartbeat_lost_out <= 1'b0;
        end
        else if (master_hb_in)
        begin
            cons_ms <= 32'h00000000;
            heartbeat_lost_out <= 1'b0;
        end
        else if (tick && cons_ms < hb_consume)
        begin
            cons_ms <= cons_ms + 32'h00000001;
        end
        else if (cons_ms >= hb_consume)
        begin
            heartbeat_lost_out <= 1'b1;
        end
        else
        begin
            cons_ms <= cons_ms;
        end
    end

endmodule

// >>> tb/fdob_bank_monitor.sv
// Port checker for the object bank
// Bound to every fdob_bank instance, single clock domain
`timescale 1ns/1ps
module fdob_bank_monitor
(
    input wire clock_in,
    input wire rst_in,
    input wire acc_valid_in,
    input wire acc_write_in,
    input wire [15:0] acc_index_in,
    input wire [31:0] acc_wdata_in,
    input wire master_hb_in,
    input wire [7:0] run_source_select_param_in,
    input wire [1:0] control_method_in,
    input wire acc_ack_out,
    input wire acc_err_out,
    input wire nv_store_out,
    input wire heartbeat_lost_out,
    input wire run_forward_out,
    input wire run_reverse_out,
    input wire [4:0] virtual_input_out,
    input wire network_external_fault_out,
    input wire fault_reset_out,
    input wire torque_ceiling_valid_out
);
    // Write request qualifier
    wire wr = acc_valid_in && acc_write_in;
    default clocking @(posedge clock_in); endclocking
    default disable iff (rst_in);
    AST_ACK_NEXT: assert property (acc_ack_out == $past(acc_valid_in))
        else $error("ack not one cycle after request");
    AST_RO_ERR: assert property (
        wr && (acc_index_in == 16'h1014 || acc_index_in == 16'h1018) |=> acc_err_out)
        else $error("read-only write not refused");
    AST_ERR_ACK: assert property (acc_err_out |-> acc_ack_out)
        else $error("error without ack");
    AST_SAVE_KEY: assert property (nv_store_out |->
        $past(wr) && $past(acc_index_in) == 16'h1010 && $past(acc_wdata_in) == 32'h65766173)
        else $error("store without keyword");
    AST_RUN_SRC: assert property (run_forward_out || run_reverse_out |->
        $past(run_source_select_param_in) == 8'h03)
        else $error("run bit with other source");
    AST_OP_CAUSE: assert property (
        $changed({virtual_input_out, network_external_fault_out, fault_reset_out})
        |-> $past(wr, 2) && $past(acc_index_in, 2) == 16'h2000)
        else $error("command output moved without write");
    AST_LOST_CLR: assert property (heartbeat_lost_out && master_hb_in |=> !heartbeat_lost_out)
        else $error("loss kept after master heartbeat");
    AST_TQ_OLV: assert property (torque_ceiling_valid_out |-> $past(control_method_in) == 2'h2)
        else $error("torque ceiling outside open loop vector");
endmodule
bind fdob_bank fdob_bank_monitor u_mon (.*);

// >>> tb/fdob_master_model.sv
// Master side model: heartbeat producer and storage engine
// Assumes one clock shared with the bank
`timescale 1ns/1ps
module fdob_master_model
(
    input wire clock_in,
    input wire rst_in,
    input wire hb_enable_in,
    input wire nv_store_in,
    input wire [31:0] nv_hb_consume_in,
    input wire [31:0] nv_hb_produce_in,
    output reg master_hb_out,
    output reg nv_done_out,
    output reg nv_valid_out,
    output reg [31:0] img_consume_out,
    output reg [31:0] img_produce_out
);
    reg [12:0] cnt; // Heartbeat spacing
    reg [2:0] dly; // Storage busy time
    // Heartbeat every 5000 cycles, below any timeout used
    always @(posedge clock_in or posedge rst_in)
        if (rst_in)
        begin
            cnt <= 13'h0000;
            master_hb_out <= 1'b0;
        end
        else
        begin
            cnt <= (cnt == 13'h1387) ? 13'h0000 : cnt + 13'h0001;
            master_hb_out <= hb_enable_in && cnt == 13'h1387;
        end
    // Image latched on store, done four cycles later
    always @(posedge clock_in or posedge rst_in)
        if (rst_in)
        begin
            dly <= 3'h0;
            nv_done_out <= 1'b0;
            nv_valid_out <= 1'b0;
            img_consume_out <= 32'h0;
            img_produce_out <= 32'h0;
        end
        else
        begin
            nv_done_out <= dly == 3'h1;
            dly <= nv_store_in ? 3'h4 : (dly != 3'h0 ? dly - 3'h1 : dly);
            if (nv_store_in)
            begin
                img_consume_out <= nv_hb_consume_in;
                img_produce_out <= nv_hb_produce_in;
                nv_valid_out <= 1'b1;
            end
        end
endmodule

// >>> tb/testbench.sv
// Self-checking bench for the object bank
// Answers are queued by the driver and popped by the ack watcher
`timescale 1ns/1ps
module testbench;
    reg clock_in = 0, rst_in = 1, acc_valid_in = 0, acc_write_in = 0, node_reset_in = 0, comm_reset_in = 0, hb_en = 1;
    reg [15:0] acc_index_in = 0;
    reg [31:0] acc_wdata_in = 0;
    reg [6:0] node_id_in = 0;
    reg [7:0] run_source_select_param_in = 8'h03;
    reg [1:0] control_method_in = 0;
    wire master_hb_in, nv_done_in, nv_valid_in, acc_ack_out, acc_err_out, nv_store_out, heartbeat_send_out;
    wire heartbeat_lost_out, run_forward_out, run_reverse_out, network_external_fault_out, fault_reset_out;
    wire torque_ceiling_valid_out;
    wire [31:0] nv_hb_consume_in, nv_hb_produce_in, acc_rdata_out, nv_hb_consume_out, nv_hb_produce_out;
    wire [4:0] virtual_input_out;
    wire [15:0] speed_reference_out, torque_ceiling_out;
    integer seed = 64377, n_mismatch = 0, samples_checked = 0, i, k;
    reg [31:0] w; // Random word
    reg [32:0] exp_ans; // Oldest queued answer
    reg [32:0] expq[$]; // Expected {err, rdata}
    fdob_bank uut (.*);
    fdob_master_model u_master (.clock_in, .rst_in, .hb_enable_in(hb_en), .nv_store_in(nv_store_out),
        .nv_hb_consume_in(nv_hb_consume_out), .nv_hb_produce_in(nv_hb_produce_out), .master_hb_out(master_hb_in),
        .nv_done_out(nv_done_in), .nv_valid_out(nv_valid_in), .img_consume_out(nv_hb_consume_in),
        .img_produce_out(nv_hb_produce_in));
    always #50 clock_in = ~clock_in;
    task cmp(input string nm, input [32:0] e, input [32:0] g);
    begin
        samples_checked++;
        if (e !== g)
        begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    end
    endtask
    task print_verdict;
    begin
        $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    end
    endtask
    // One access, answer noted in the queue
    task acc(input wr, input [15:0] ix, input [31:0] d, input [32:0] e);
    begin
        @(posedge clock_in) #1;
        acc_valid_in = 1;
        acc_write_in = wr;
        acc_index_in = ix;
        acc_wdata_in = d;
        expq.push_back(e);
        @(posedge clock_in) #1;
        acc_valid_in = 0;
    end
    endtask
    // Cycles until heartbeat (0), loss (1) or loss cleared (2), bounded
    task count(input [1:0] sel, input integer lim, input must);
    begin
        k = 0;
        do
        begin
            @(posedge clock_in) #2;
            k++;
        end while ((sel == 2'h0 ? heartbeat_send_out : heartbeat_lost_out ^ sel[1]) !== 1'b1 && k < lim);
        // A required event that never came ends the run
        if (must && k >= lim)
        begin
            n_mismatch++;
            $display("[ERR] wait %0d expected 1 seen 0", sel);
            print_verdict;
        end
    end
    endtask
    // Ack watcher
    always @(posedge clock_in)
    begin
        #2;
        if (acc_ack_out === 1'b1)
        begin
            exp_ans = expq.size() ? expq.pop_front() : 33'h1FFFFFFFF;
            cmp("access", exp_ans, {acc_err_out, acc_rdata_out});
        end
    end
    initial
    begin
        node_id_in = $random(seed);
        repeat (20) @(posedge clock_in);
        #1 rst_in = 0;
        acc(0, 16'h1014, 0, {1'b0, 25'h1, node_id_in});
        acc(1, 16'h1014, 5, 33'h100000000);
        acc(0, 16'h1018, 0, 33'h000001234);
        acc(1, 16'h1018, 5, 33'h100000000);
        acc(1, 16'h2030, 5, 33'h100000000);
        // Reset event with no valid stored image falls back to defaults
        acc(1, 16'h1017, 7, 0);
        @(posedge clock_in) #1 comm_reset_in = 1;
        @(posedge clock_in) #1 comm_reset_in = 0;
        acc(0, 16'h1017, 0, 0);
        acc(1, 16'h1016, 3, 0);
        acc(1, 16'h1017, 7, 0);
        acc(1, 16'h1010, 32'h64616F6C, 0);
        cmp("no store", 0, nv_store_out);
        acc(1, 16'h1010, 32'h65766173, 0);
        cmp("store", {1'b1, 32'h7}, {nv_store_out, nv_hb_produce_out});
        cmp("store img", 3, nv_hb_consume_out);
        acc(0, 16'h1010, 0, 1);
        for (i = 0; i < 2; i++)
        begin
            acc(1, 16'h1017, 9, 0);
            acc(0, 16'h1017, 0, 9);
            repeat (6) @(posedge clock_in);
            #1 {comm_reset_in, node_reset_in} = i[0] ? 2'h2 : 2'h1;
            @(posedge clock_in) #1 {comm_reset_in, node_reset_in} = 0;
            acc(0, 16'h1017, 0, 7);
        end
        acc(1, 16'h1011, 32'h12345678, 0);
        acc(0, 16'h1016, 0, 3);
        acc(1, 16'h1011, 32'h64616F6C, 0);
        acc(0, 16'h1016, 0, 0);
        acc(0, 16'h1017, 0, 0);
        for (i = 0; i < 8; i++)
        begin
            w = $random(seed);
            run_source_select_param_in = i[0] ? 8'h03 : 8'h04 + i[7:0];
            acc(1, 16'h2000, w, 0);
            @(posedge clock_in) #1;
            cmp("run", {w[1:0] & {2{i[0]}}}, {run_reverse_out, run_forward_out});
            cmp("vin", w[6:2], virtual_input_out);
            cmp("flt", w[9:8], {fault_reset_out, network_external_fault_out});
            acc(0, 16'h2000, 0, w[15:0] & 16'h037F);
        end
        for (i = 0; i < 4; i++)
        begin
            w = $random(seed);
            control_method_in = i[1:0];
            acc(1, 16'h2010, w, 0);
            acc(1, 16'h2020, w >> 16, 0);
            acc(0, 16'h2010, 0, w[15:0]);
            cmp("ref", w, {torque_ceiling_out, speed_reference_out});
            cmp("olv", i == 2, torque_ceiling_valid_out);
        end
        acc(1, 16'h1017, 1, 0);
        count(0, 12000, 1);
        cmp("hb seen", 1, heartbeat_send_out);
        count(0, 12000, 1);
        cmp("hb period", 10000, k);
        acc(1, 16'h1017, 0, 0);
        count(0, 11000, 0);
        cmp("hb silent", 11000, k);
        acc(1, 16'h1016, 2, 0);
        count(1, 22000, 0);
        cmp("no loss", 22000, k);
        hb_en = 0;
        count(1, 22000, 1);
        cmp("loss", 1, heartbeat_lost_out);
        acc(1, 16'h1016, 0, 0);
        @(posedge clock_in) #1;
        cmp("loss off", 0, heartbeat_lost_out);
        // Short timeout trips again, then a master beat clears it
        acc(1, 16'h1016, 1, 0);
        count(1, 11000, 1);
        cmp("loss 1ms", 1, heartbeat_lost_out);
        hb_en = 1;
        count(2'h2, 6000, 1);
        cmp("loss cleared", 0, heartbeat_lost_out);
        cmp("pending", 0, expq.size());
        print_verdict;
    end
endmodule
